// file: design/t1_prescale.sv
`timescale 1ns/100ps
//Contract
// R1 - two modes: system or fast time base
// R2 - fast select one gives asynchronous mode
// R3 - fast select zero gives system clock
// R4 - divisors one through 16384 plus stop
// R5 - fast clock halves under low speed
// R6 - low speed refused when pll clocks system
// R7 - software stops timer before low speed change
// R8 - prescaler clear resets prescaler, not counter
// R9 - clear self-clears, zero ignored, reads zero
// R10 - software enables pll, waits, polls lock
// R11 - fast select accepted only with pll on
// R12 - software sets fast select only locked
// R13 - turn-on starts pll and rc reference; here rc starts only while I_RC_REF_NEEDED is high
// R14 - turn-on reads one when pll clocks system
// R15 - lock flag shows pll locked state
// R16 - pll register bits 6:3 read zero
// R17 - select codes: stop, one, doubling divisors
// R18 - mode switch makes no truncated pulses
module t1_prescale
	import t1_prescale_pkg::*;
#(
	parameter int PRESC_W = PRESCALE_W
) (
	input wire logic I_CLK_SYS,
	input wire logic I_NRST,
	input wire logic [ADDR_W-1:0] I_ADDR,
	input wire logic [DATA_W-1:0] I_WDATA,
	input wire logic I_WE,
	input wire logic I_RE,
	input wire logic I_FAST_TICK,
	input wire logic I_PLL_LOCKED,
	input wire logic I_RC_REF_NEEDED,
	input wire logic [3:0] I_CLOCK_SOURCE_FUSE,
	output logic [DATA_W-1:0] O_RDATA,
	output logic O_TIMER_TICK,
	output logic O_PLL_ENABLE,
	output logic O_RC_OSC_ENABLE,
	output logic O_ASYNC_MODE,
	output logic O_LOW_SPEED,
	output logic [1:0] O_DEAD_TIME_PRESCALE
);

	// request bundle from the plain port pins
	reg_req_s req;
	assign req = '{addr: I_ADDR, wdata: I_WDATA, we: I_WE, re: I_RE};

	// decoded strobes
	logic wr_tpc;
	logic wr_pll;
	logic psr_wr;
	logic pll_sysclk;
	logic pll_on;
	assign wr_tpc = req.we && (req.addr == TIMER1_PRESCALE_CONTROL_ADDR);
	assign wr_pll = req.we && (req.addr == PLL_CONTROL_STATUS_ADDR);
	// a zero in the clear bit does nothing
	assign psr_wr = wr_tpc && req.wdata[PRESCALER_CLEAR_BIT]; // R9
	assign pll_sysclk = (I_CLOCK_SOURCE_FUSE == FUSE_PLL_SYSCLK);

	// tap decode for the tick logic
	function automatic logic tap_hit(input logic [3:0] cs,
		input logic [PRESC_W-1:0] cnt);
		logic [PRESC_W-1:0] mask;
		mask = '0;
		if (cs == 4'h0) begin
			return 1'b0; // stopped
		end
		mask = PRESC_W'((1 << (cs - 4'h1)) - 1);
		return (cnt & mask) == mask; // R17
	endfunction

	// control register state
	logic [3:0] cs_reg, cs_next; // clock select bits 3..0
	logic [1:0] dtps_reg, dtps_next; // dead-time prescale, passed on
	logic rsv7_reg, rsv7_next; // read/write spare bit
	logic lsm_reg, lsm_next; // low speed select
	logic fast_clock_select_reg, fast_clock_select_next; // fast clock select
	logic pll_turn_on_reg, pll_turn_on_next; // pll turn-on
	// the pll counts as on through the fuse or the turn-on bit
	assign pll_on = pll_sysclk || pll_turn_on_reg; // R11

	// next control values from register writes
	always_comb begin
		cs_next = cs_reg;
		dtps_next = dtps_reg;
		rsv7_next = rsv7_reg;
		lsm_next = lsm_reg;
		fast_clock_select_next = fast_clock_select_reg;
		pll_turn_on_next = pll_turn_on_reg;
		if (wr_tpc) begin
			cs_next = req.wdata[CLOCK_SELECT_LO_BIT +: 4]; // R4
			dtps_next = req.wdata[DEAD_TIME_LO_BIT +: 2];
			rsv7_next = req.wdata[RESERVED7_BIT];
		end
		if (wr_pll) begin
			pll_turn_on_next = req.wdata[PLL_TURN_ON_BIT]; // R13
			// low speed cannot rise while the pll drives the cpu
			if (!(pll_sysclk && req.wdata[LOW_SPEED_SELECT_BIT])) begin
				lsm_next = req.wdata[LOW_SPEED_SELECT_BIT]; // R6
			end
			// a one only sticks if the pll already runs
			if (req.wdata[FAST_CLOCK_SELECT_BIT]) begin
				fast_clock_select_next = pll_on ? 1'b1 : fast_clock_select_reg; // R11
			end else begin
				fast_clock_select_next = 1'b0; // R3
			end
		end
	end

	// control registers
	always_ff @(posedge I_CLK_SYS) begin
		if (!I_NRST) begin
			cs_reg <= TIMER1_PRESCALE_CONTROL_RST[3:0];
			dtps_reg <= TIMER1_PRESCALE_CONTROL_RST[5:4];
			rsv7_reg <= TIMER1_PRESCALE_CONTROL_RST[7];
			lsm_reg <= PLL_CONTROL_STATUS_RST[7];
			fast_clock_select_reg <= PLL_CONTROL_STATUS_RST[2];
			pll_turn_on_reg <= PLL_CONTROL_STATUS_RST[1];
		end else begin
			cs_reg <= cs_next;
			dtps_reg <= dtps_next;
			rsv7_reg <= rsv7_next;
			lsm_reg <= lsm_next;
			fast_clock_select_reg <= fast_clock_select_next;
			pll_turn_on_reg <= pll_turn_on_next;
		end
	end

	// prescaler datapath state
	logic [PRESC_W-1:0] cnt_reg, cnt_next; // ripple of base ticks
	logic half_reg, half_next; // low speed halving phase
	logic mode_reg, mode_next; // mode actually in use
	logic tick_reg, tick_next; // divided timer clock enable
	logic base_tick; // one undivided time base period
	logic switching; // mode change in progress

	// the fast clock arrives as a tick; low speed keeps every other one
	assign base_tick = mode_reg ?
		(I_FAST_TICK && (!lsm_reg || half_reg)) : 1'b1; // R1 R5
	assign switching = (mode_reg != fast_clock_select_reg);

	// next prescaler values
	always_comb begin
		cnt_next = cnt_reg;
		half_next = half_reg;
		mode_next = fast_clock_select_reg; // R2 R3
		tick_next = 1'b0;
		if (mode_reg && I_FAST_TICK) begin
			half_next = !half_reg; // R5
		end
		if (psr_wr || switching) begin
			// restart the division so the first pulse is whole
			cnt_next = '0; // R8 R18
			half_next = 1'b0;
		end else if (base_tick) begin
			tick_next = tap_hit(cs_reg, cnt_reg); // R4 R17
			cnt_next = cnt_reg + PRESC_W'(1);
		end
	end

	// prescaler registers; the timer counter itself is elsewhere
	always_ff @(posedge I_CLK_SYS) begin
		if (!I_NRST) begin
			cnt_reg <= '0;
			half_reg <= 1'b0;
			mode_reg <= 1'b0;
			tick_reg <= 1'b0;
		end else begin
			cnt_reg <= cnt_next;
			half_reg <= half_next;
			mode_reg <= mode_next;
			tick_reg <= tick_next;
		end
	end

	// read data and pll drive state
	logic [DATA_W-1:0] rdata_reg, rdata_next; // registered read word
	logic pll_en_reg, pll_en_next; // pll run request
	logic rc_reg, rc_next; // rc reference run request

	// read mux; unmapped addresses read zero
	always_comb begin
		rdata_next = rdata_reg;
		pll_en_next = pll_on; // R13
		rc_next = pll_on && I_RC_REF_NEEDED; // R13
		if (req.re) begin
			rdata_next = '0;
			if (req.addr == TIMER1_PRESCALE_CONTROL_ADDR) begin
				rdata_next[RESERVED7_BIT] = rsv7_reg;
				rdata_next[PRESCALER_CLEAR_BIT] = 1'b0; // R9
				rdata_next[DEAD_TIME_LO_BIT +: 2] = dtps_reg;
				rdata_next[CLOCK_SELECT_LO_BIT +: 4] = cs_reg;
			end else if (req.addr == PLL_CONTROL_STATUS_ADDR) begin
				// bits 6:3 stay at the zero set above
				rdata_next[LOW_SPEED_SELECT_BIT] = lsm_reg; // R16
				rdata_next[FAST_CLOCK_SELECT_BIT] = fast_clock_select_reg;
				rdata_next[PLL_TURN_ON_BIT] = pll_on; // R14
				rdata_next[PLL_LOCK_FLAG_BIT] = I_PLL_LOCKED; // R15
			end
		end
	end

	// read and pll registers
	always_ff @(posedge I_CLK_SYS) begin
		if (!I_NRST) begin
			rdata_reg <= '0;
			pll_en_reg <= 1'b0;
			rc_reg <= 1'b0;
		end else begin
			rdata_reg <= rdata_next;
			pll_en_reg <= pll_en_next;
			rc_reg <= rc_next;
		end
	end

	// outputs straight from flip-flops
	assign O_RDATA = rdata_reg;
	assign O_TIMER_TICK = tick_reg;
	assign O_PLL_ENABLE = pll_en_reg;
	assign O_RC_OSC_ENABLE = rc_reg;
	assign O_ASYNC_MODE = mode_reg;
	assign O_LOW_SPEED = lsm_reg;
	assign O_DEAD_TIME_PRESCALE = dtps_reg;

	// checks
	property p_stop;
		@(posedge I_CLK_SYS) disable iff (!I_NRST)
		(cs_reg == 4'h0) |=> !O_TIMER_TICK;
	endproperty
	a_stop: assert property (p_stop) // R4
		else $error("tick while stopped");

	property p_sync_full;
		@(posedge I_CLK_SYS) disable iff (!I_NRST)
		(!mode_reg && !fast_clock_select_reg && cs_reg == 4'h1 && !psr_wr)
			|=> O_TIMER_TICK;
	endproperty
	a_sync_full: assert property (p_sync_full) // R3
		else $error("sync undivided tick missing");

	property p_async_tick;
		@(posedge I_CLK_SYS) disable iff (!I_NRST)
		(mode_reg && fast_clock_select_reg && !lsm_reg && cs_reg == 4'h1
			&& I_FAST_TICK && !psr_wr) |=> O_TIMER_TICK;
	endproperty
	a_async_tick: assert property (p_async_tick) // R2
		else $error("async tick missing");

	property p_async_base;
		@(posedge I_CLK_SYS) disable iff (!I_NRST)
		(mode_reg && !I_FAST_TICK) |=> !O_TIMER_TICK;
	endproperty
	a_async_base: assert property (p_async_base) // R1
		else $error("async tick without fast clock");

	property p_low_half;
		@(posedge I_CLK_SYS) disable iff (!I_NRST)
		(O_TIMER_TICK && mode_reg && fast_clock_select_reg && lsm_reg
			&& cs_reg == 4'h1 && !psr_wr) |=> !O_TIMER_TICK;
	endproperty
	a_low_half: assert property (p_low_half) // R5
		else $error("low speed did not halve");

	property p_lsm_refused;
		@(posedge I_CLK_SYS) disable iff (!I_NRST)
		(wr_pll && pll_sysclk && !lsm_reg) |=> !O_LOW_SPEED;
	endproperty
	a_lsm_refused: assert property (p_lsm_refused) // R6
		else $error("low speed set with pll system clock");

	property p_fast_clock_select_gate;
		@(posedge I_CLK_SYS) disable iff (!I_NRST)
		(wr_pll && !pll_on && !fast_clock_select_reg) |=> !fast_clock_select_reg;
	endproperty
	a_fast_clock_select_gate: assert property (p_fast_clock_select_gate) // R11
		else $error("fast select accepted without pll");

	property p_psr_clear;
		@(posedge I_CLK_SYS) disable iff (!I_NRST)
		psr_wr |=> (cnt_reg == '0) && !O_TIMER_TICK;
	endproperty
	a_psr_clear: assert property (p_psr_clear) // R8
		else $error("prescaler not cleared");

	property p_psr_read;
		@(posedge I_CLK_SYS) disable iff (!I_NRST)
		(req.re && req.addr == TIMER1_PRESCALE_CONTROL_ADDR)
			|=> !O_RDATA[PRESCALER_CLEAR_BIT];
	endproperty
	a_psr_read: assert property (p_psr_read) // R9
		else $error("clear bit read as one");

	property p_pll_read;
		@(posedge I_CLK_SYS) disable iff (!I_NRST)
		(req.re && req.addr == PLL_CONTROL_STATUS_ADDR)
			|=> (O_RDATA[6:3] == 4'h0) // R16
			&& (O_RDATA[PLL_LOCK_FLAG_BIT] == $past(I_PLL_LOCKED)) // R15
			&& (O_RDATA[PLL_TURN_ON_BIT] == $past(pll_on)); // R14
	endproperty
	a_pll_read: assert property (p_pll_read) // R14
		else $error("pll status read wrong");

	property p_pll_start;
		@(posedge I_CLK_SYS) disable iff (!I_NRST)
		// the run request is registered from pll_on, so it trails a cycle
		$rose(pll_turn_on_reg) |=> O_PLL_ENABLE;
	endproperty
	a_pll_start: assert property (p_pll_start) // R13
		else $error("pll not started");

	property p_switch;
		@(posedge I_CLK_SYS) disable iff (!I_NRST)
		switching |=> !O_TIMER_TICK ##0 (cnt_reg == '0);
	endproperty
	a_switch: assert property (p_switch) // R18
		else $error("pulse across mode switch");

endmodule

// file: design/t1_prescale_pkg.sv
package t1_prescale_pkg;
	// register port geometry
	localparam int ADDR_W = 6;
	localparam int DATA_W = 8;
	// register addresses on the documented port
	localparam logic [5:0] TIMER1_PRESCALE_CONTROL_ADDR = 6'h2f;
	localparam logic [5:0] PLL_CONTROL_STATUS_ADDR = 6'h29;
	// timer1_prescale_control field positions
	localparam int PRESCALER_CLEAR_BIT = 6;
	localparam int RESERVED7_BIT = 7;
	localparam int DEAD_TIME_LO_BIT = 4;
	localparam int CLOCK_SELECT_LO_BIT = 0;
	// pll_control_status field positions
	localparam int LOW_SPEED_SELECT_BIT = 7;
	localparam int FAST_CLOCK_SELECT_BIT = 2;
	localparam int PLL_TURN_ON_BIT = 1;
	localparam int PLL_LOCK_FLAG_BIT = 0;
	// reset values
	localparam logic [7:0] TIMER1_PRESCALE_CONTROL_RST = 8'h00;
	localparam logic [7:0] PLL_CONTROL_STATUS_RST = 8'h00;
	// fuse code that makes the pll the system clock
	localparam logic [3:0] FUSE_PLL_SYSCLK = 4'h1;
	// prescaler geometry: largest divisor is 2**14
	localparam int PRESCALE_W = 14;
	// pll settle time that software waits, and its cycle count
	localparam int CLK_PERIOD_NS = 40;
	localparam int PLL_SETTLE_US = 100;
	localparam int PLL_SETTLE_CYCLES =
		(PLL_SETTLE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// one register port request
	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic we;
		logic re;
	} reg_req_s;
endpackage

// file: test/t1_prescale_tb.sv
`timescale 1ns/100ps
module t1_prescale_tb;
	import t1_prescale_pkg::*;
	logic clk, nrst, we, re, fast, locked, rc_need; // bench-driven inputs
	logic [ADDR_W-1:0] addr; // register address
	logic [DATA_W-1:0] wdata, rdata; // register data both ways
	logic [3:0] fuse; // clock source fuse
	logic tick, pll_en, rc_en, async_md, low_spd; // observed levels
	logic [1:0] dead; // stored dead time field
	int errors, num_checks, n1, n2; // counters and measured delays

	t1_prescale dut (.I_CLK_SYS(clk), .I_NRST(nrst), .I_ADDR(addr),
		.I_WDATA(wdata), .I_WE(we), .I_RE(re), .I_FAST_TICK(fast),
		.I_PLL_LOCKED(locked), .I_RC_REF_NEEDED(rc_need),
		.I_CLOCK_SOURCE_FUSE(fuse), .O_RDATA(rdata), .O_TIMER_TICK(tick),
		.O_PLL_ENABLE(pll_en), .O_RC_OSC_ENABLE(rc_en),
		.O_ASYNC_MODE(async_md), .O_LOW_SPEED(low_spd),
		.O_DEAD_TIME_PRESCALE(dead));

	// 25 mhz system clock
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	// fast time base: one pulse every second system cycle
	always @(posedge clk) begin
		fast <= nrst ? ~fast : 1'b0;
	end

	// four-state compare, so an unknown never matches
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp) begin
			errors++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// one-cycle write strobe, effect lands one edge later
	task automatic wr(input logic [5:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		we <= 1'b1;
		@(posedge clk);
		we <= 1'b0;
		@(posedge clk);
	endtask

	// read data is registered, sampled a full cycle later
	task automatic rd(input logic [5:0] a, input logic [7:0] exp);
		@(posedge clk);
		addr <= a;
		re <= 1'b1;
		@(posedge clk);
		re <= 1'b0;
		@(posedge clk);
		@(negedge clk);
		chk({8'h00, rdata}, {8'h00, exp});
	endtask

	// resync to a tick, then time the gap to the next one
	task automatic per(input int d);
		int n;
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while (tick !== 1'b1 && n < 2 * d + 8);
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while (tick !== 1'b1 && n < 2 * d + 8);
		chk(16'(n), 16'(d));
	endtask

	// clear the prescaler and time the first tick after it
	task automatic clr(output int n);
		wr(TIMER1_PRESCALE_CONTROL_ADDR, 8'h43);
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while (tick !== 1'b1 && n < 40);
	endtask

	task automatic end_of_test();
		$display("checks=%0d mismatches=%0d", num_checks, errors);
		if (errors == 0 && num_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	// watchdog sized well past the longest divider sweep
	initial begin
		#(40 * 90000);
		errors++;
		$display("watchdog expired");
		end_of_test();
	end

	// main sequence
	initial begin
		errors = 0;
		num_checks = 0;
		nrst = 1'b0;
		we = 1'b0;
		re = 1'b0;
		addr = '0;
		wdata = '0;
		locked = 1'b0;
		rc_need = 1'b1;
		fuse = 4'h0;
		repeat (12) @(posedge clk);
		nrst <= 1'b1;
		rd(TIMER1_PRESCALE_CONTROL_ADDR, TIMER1_PRESCALE_CONTROL_RST);
		rd(PLL_CONTROL_STATUS_ADDR, PLL_CONTROL_STATUS_RST);
		$display("test reset done");
		// all fields set; clear bit must read back low
		wr(TIMER1_PRESCALE_CONTROL_ADDR, 8'hf1);
		rd(TIMER1_PRESCALE_CONTROL_ADDR, 8'hb1);
		chk(16'(dead), 16'h3);
		wr(6'h00, 8'hff);
		rd(6'h00, 8'h00);
		$display("test fields done");
		// every select code in synchronous mode, stop included
		for (int cs = 0; cs < 16; cs++) begin
			wr(TIMER1_PRESCALE_CONTROL_ADDR, 8'(cs));
			if (cs == 0) begin
				n1 = 0;
				repeat (64) @(negedge clk) n1 += int'(tick === 1'b1);
				chk(16'(n1), 16'h0);
			end else begin
				per(1 << (cs - 1));
			end
		end
		$display("test dividers done");
		// clear at two phases must restart identically
		wr(TIMER1_PRESCALE_CONTROL_ADDR, 8'h03);
		clr(n1);
		@(posedge clk);
		clr(n2);
		chk(16'(n1), 16'h4);
		chk(16'(n2), 16'(n1));
		rd(TIMER1_PRESCALE_CONTROL_ADDR, 8'h03);
		$display("test clear done");
		// fast select refused until the pll was already on
		wr(PLL_CONTROL_STATUS_ADDR, 8'h7c);
		rd(PLL_CONTROL_STATUS_ADDR, 8'h00);
		wr(PLL_CONTROL_STATUS_ADDR, 8'h06);
		rd(PLL_CONTROL_STATUS_ADDR, 8'h02);
		chk(16'({pll_en, rc_en, async_md}), 16'h6);
		@(posedge clk);
		rc_need <= 1'b0;
		@(posedge clk);
		@(posedge clk);
		@(negedge clk);
		chk(16'(rc_en), 16'h0);
		repeat (PLL_SETTLE_CYCLES) @(posedge clk);
		locked <= 1'b1;
		rd(PLL_CONTROL_STATUS_ADDR, 8'h03);
		// timer stopped around every low speed change
		wr(TIMER1_PRESCALE_CONTROL_ADDR, 8'h00);
		wr(PLL_CONTROL_STATUS_ADDR, 8'h86);
		rd(PLL_CONTROL_STATUS_ADDR, 8'h87);
		chk(16'({async_md, low_spd}), 16'h3);
		wr(TIMER1_PRESCALE_CONTROL_ADDR, 8'h01);
		per(4);
		wr(TIMER1_PRESCALE_CONTROL_ADDR, 8'h00);
		wr(PLL_CONTROL_STATUS_ADDR, 8'h06);
		wr(TIMER1_PRESCALE_CONTROL_ADDR, 8'h01);
		per(2);
		wr(TIMER1_PRESCALE_CONTROL_ADDR, 8'h02);
		per(4);
		// back to the system clock
		wr(PLL_CONTROL_STATUS_ADDR, 8'h00);
		rd(PLL_CONTROL_STATUS_ADDR, 8'h01);
		chk(16'({pll_en, async_md}), 16'h0);
		per(2);
		$display("test modes done");
		// pll as system clock: low speed refused, turn-on reads one
		@(posedge clk);
		fuse <= FUSE_PLL_SYSCLK;
		wr(TIMER1_PRESCALE_CONTROL_ADDR, 8'h00);
		wr(PLL_CONTROL_STATUS_ADDR, 8'h80);
		rd(PLL_CONTROL_STATUS_ADDR, 8'h03);
		chk(16'({pll_en, low_spd}), 16'h2);
		wr(PLL_CONTROL_STATUS_ADDR, 8'h04);
		rd(PLL_CONTROL_STATUS_ADDR, 8'h07);
		$display("test fuse done");
		end_of_test();
	end
endmodule
